// ===== logic/sar_adc_control.sv
// Purpose: control of an 8-bit successive-approximation converter
// Assumes: comparator and analog mux outside; one clock, sync reset
// Notes:   start is a one-cycle request from logic on this clock
//
// Overview of operation
// [R1] eight-bit code, resolved MSB first
// [R2] one of three channels feeds sample-hold
// [R3] finished code written to result register
// [R4] interrupt request on each conversion complete
// [R5] completion interrupt wakes device from sleep
// [R6] software waits acquisition time before start
// [R7] reference selectable, internal reference available
// [R8] busy set at start, cleared with result
`include "sar_adc_cfg.svh"

module sar_adc_control
    import sar_adc_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    input  wire conv_cfg_s            cfg,
    input  wire logic                 start,
    input  wire logic                 sleeping,
    input  wire logic                 irq_clear,
    input  wire logic                 cmp_pin,
    output logic [`ADC_CHANNELS-1:0]  chan_sel,
    output logic                      sample_en,
    output logic                      ref_internal,
    output logic [`ADC_BITS-1:0]      dac_code,
    output logic [`ADC_BITS-1:0]      conversion_result_reg,
    output logic                      busy,
    output logic                      irq,
    output logic                      wake
);

    // ****************************************************
    // comparator synchroniser
    // ****************************************************
    logic cmp_meta_q;
    logic cmp_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cmp_meta_q <= 1'b0;
            cmp_q      <= 1'b0;
        end else begin
            cmp_meta_q <= cmp_pin;
            cmp_q      <= cmp_meta_q;
        end
    end

    // ****************************************************
    // conversion sequencer
    // ****************************************************
    conv_state_e          state_q,   state_d;
    logic [2:0]           bit_q,     bit_d;
    logic [1:0]           settle_q,  settle_d;
    logic [`ADC_BITS-1:0] trial_q,   trial_d;
    logic                 start_ok;
    logic                 done;

    always_comb begin
        state_d  = state_q;
        bit_d    = bit_q;
        settle_d = settle_q;
        trial_d  = trial_q;
        start_ok = 1'b0;
        done     = 1'b0;
        case (state_q)
            ST_IDLE: begin
                // acquisition time is left to software
                if (start) begin
                    start_ok = 1'b1;
                    bit_d    = `ADC_MSB;
                    trial_d  = `ADC_TRIAL_INIT; // R1
                    settle_d = `ADC_SETTLE_CYC;
                    state_d  = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                // dac level settles and crosses the synchroniser
                if (settle_q == 2'h0) begin
                    state_d = ST_COMPARE;
                end else begin
                    settle_d = settle_q - 2'h1;
                end
            end
            ST_COMPARE: begin
                // keep trial bit when input at or above dac level
                if (!cmp_q) begin
                    trial_d[bit_q] = 1'b0; // R1
                end
                if (bit_q == 3'h0) begin
                    done    = 1'b1;
                    state_d = ST_IDLE;
                end else begin
                    bit_d                 = bit_q - 3'h1;
                    trial_d[bit_q - 3'h1] = 1'b1; // R1
                    settle_d              = `ADC_SETTLE_CYC;
                    state_d               = ST_SETTLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q  <= ST_IDLE;
            bit_q    <= 3'h0;
            settle_q <= 2'h0;
            trial_q  <= 8'h00;
        end else begin
            state_q  <= state_d;
            bit_q    <= bit_d;
            settle_q <= settle_d;
            trial_q  <= trial_d;
        end
    end

    // ****************************************************
    // result register and busy flag
    // ****************************************************
    logic [`ADC_BITS-1:0] result_q,  result_d;
    logic                 busy_q,    busy_d;

    always_comb begin
        result_d = result_q;
        busy_d   = busy_q;
        if (start_ok) begin
            busy_d = 1'b1; // R8
        end
        if (done) begin
            result_d = trial_d; // R3
            busy_d   = 1'b0; // R8
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            result_q <= `ADC_RESULT_RST;
            busy_q   <= 1'b0;
        end else begin
            result_q <= result_d;
            busy_q   <= busy_d;
        end
    end

    // ****************************************************
    // sample-and-hold tracking
    // ****************************************************
    logic samp_q, samp_d;

    always_comb begin
        // track while idle, hold from start to result
        samp_d = (state_d == ST_IDLE); // R2
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            samp_q <= 1'b0;
        end else begin
            samp_q <= samp_d;
        end
    end

    // ****************************************************
    // channel decode and reference select
    // ****************************************************
    wire  [`ADC_CHANNELS-1:0] chan_hit;
    logic [`ADC_CHANNELS-1:0] chan_q,  chan_d;
    logic                     ref_q,   ref_d;

    // channel code 3 selects no input
    for (genvar g = 0; g < `ADC_CHANNELS; g++) begin : g_chan
        assign chan_hit[g] = (cfg.channel == `ADC_CH_W'(g)); // R2
    end

    always_comb begin
        chan_d = chan_hit; // R2
        ref_d  = cfg.ref_internal; // R7
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            chan_q <= '0;
            ref_q  <= 1'b0;
        end else begin
            chan_q <= chan_d;
            ref_q  <= ref_d;
        end
    end

    // ****************************************************
    // completion interrupt and wake request
    // ****************************************************
    logic irq_q,  irq_d;
    logic wake_q, wake_d;

    always_comb begin
        // a completion in the clearing cycle wins
        irq_d  = (irq_q && !irq_clear) || (done && cfg.irq_enable); // R4
        wake_d = irq_d && sleeping; // R5
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_q  <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            irq_q  <= irq_d;
            wake_q <= wake_d;
        end
    end

    // ****************************************************
    // outputs, all straight from flip-flops
    // ****************************************************
    assign chan_sel              = chan_q;
    assign sample_en             = samp_q;
    assign ref_internal          = ref_q;
    assign dac_code              = trial_q;
    assign conversion_result_reg = result_q;
    assign busy                  = busy_q;
    assign irq                   = irq_q;
    assign wake                  = wake_q;

endmodule : sar_adc_control

// ===== logic/sar_adc_cfg.svh
// Purpose: constants for the successive-approximation converter control
// Assumes: 50 MHz clock
// Notes:   definitions only
`ifndef SAR_ADC_CFG_SVH
`define SAR_ADC_CFG_SVH

`define ADC_BITS        8
`define ADC_CHANNELS    3
`define ADC_CH_W        2
`define ADC_MSB         3'h7
`define ADC_TRIAL_INIT  8'h80
`define ADC_RESULT_RST  8'h00
`define ADC_SETTLE_CYC  2'h1

`endif

// ===== logic/sar_adc_pkg.sv
// Purpose: types for the successive-approximation converter control
// Assumes: constants header included
// Notes:   none
`include "sar_adc_cfg.svh"

package sar_adc_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SETTLE,
        ST_COMPARE
    } conv_state_e;

    typedef struct packed {
        logic [`ADC_CH_W-1:0] channel;
        logic                 ref_internal;
        logic                 irq_enable;
    } conv_cfg_s;

endpackage : sar_adc_pkg

// ===== verif/sar_adc_control_monitor.sv
// Purpose: port checks of converter control
// Assumes: bound to sar_adc_control
// Notes:   24 cycles per conversion
module sar_adc_control_monitor
    import sar_adc_pkg::*;
(
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire conv_cfg_s  cfg,
    input wire logic       start,
    input wire logic       sleeping,
    input wire logic [2:0] chan_sel,
    input wire logic       sample_en,
    input wire logic       ref_internal,
    input wire logic [7:0] dac_code,
    input wire logic [7:0] conversion_result_reg,
    input wire logic       busy,
    input wire logic       irq,
    input wire logic       wake
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_msb_first: assert property (start && !busy |=> dac_code == 8'h80)
        else $error("first trial not 0x80");
    a_chan_route: assert property (!$past(sys_rst) |-> chan_sel ==
        (($past(cfg.channel) == 2'h3) ? 3'h0 : 3'h1 << $past(cfg.channel)))
        else $error("channel select wrong");
    a_hold_off: assert property (busy |-> !sample_en)
        else $error("tracking during conversion");
    a_result_hold: assert property (!$fell(busy) |->
        $stable(conversion_result_reg)) else $error("result moved");
    a_irq_done: assert property ($fell(busy) && $past(cfg.irq_enable)
        |-> irq) else $error("no irq on completion");
    a_wake_sleep: assert property (wake == (irq && $past(sleeping)))
        else $error("wake wrong");
    a_ref_copy: assert property (!$past(sys_rst) |->
        ref_internal == $past(cfg.ref_internal)) else $error("ref wrong");
    a_busy_span: assert property (start && !busy |-> ##24 busy ##1 !busy)
        else $error("busy span wrong");
endmodule : sar_adc_control_monitor

bind sar_adc_control sar_adc_control_monitor sar_adc_control_monitor_i (
    .clk, .sys_rst, .cfg, .start, .sleeping, .chan_sel, .sample_en,
    .ref_internal, .dac_code, .conversion_result_reg, .busy, .irq, .wake);

// ===== verif/sar_adc_analog.sv
// Purpose: analog sources and ideal comparator
// Assumes: three fixed levels
// Notes:   no channel selected gives 0
module sar_adc_analog (
    input  wire logic [2:0] chan_sel,
    input  wire logic [7:0] dac_code,
    input  wire logic [7:0] lvl [3],
    output logic            cmp_pin
);
    always_comb begin
        cmp_pin = 1'b0;
        for (int i = 0; i < 3; i++) begin
            if (chan_sel[i] && lvl[i] >= dac_code) cmp_pin = 1'b1;
        end
    end
endmodule : sar_adc_analog

// ===== verif/tb_sar_adc_control.sv
// Purpose: self-checking bench of converter control
// Assumes: 50 MHz clock
// Notes:   result equals the selected level
module tb_sar_adc_control
    import sar_adc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, sys_rst = 1'b1, start = 1'b0;
    logic        sleeping = 1'b0, irq_clear = 1'b0;
    conv_cfg_s   cfg = '0;
    logic        cmp_pin, sample_en, ref_internal, busy, irq, wake;
    logic [2:0]  chan_sel;
    logic [7:0]  dac_code, res;
    logic [7:0]  lvl [3] = '{8'hA5, 8'h00, 8'hFF};
    logic [11:0] rows [4] = '{12'h1A5, 12'h600, 12'h9FF, 12'hF00};
    int          n_fail = 0, num_checks = 0;
    always #10 clk = ~clk;
    sar_adc_analog sar_adc_analog_i (.chan_sel, .dac_code, .lvl, .cmp_pin);
    sar_adc_control sar_adc_control_i (.clk, .sys_rst, .cfg, .start,
        .sleeping, .irq_clear, .cmp_pin, .chan_sel, .sample_en,
        .ref_internal, .dac_code, .conversion_result_reg(res), .busy, .irq,
        .wake);
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task give_verdict;
        $display("checks %0d fails %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    // start, optional refused restart, wait for done
    task conv(input bit again);
        int k;
        @(posedge clk) start <= 1'b1;
        @(posedge clk) start <= 1'b0;
        repeat (4) @(posedge clk);
        start <= again;
        @(posedge clk) start <= 1'b0;
        for (k = 0; k < 40 && busy !== 1'b0; k++) @(negedge clk);
        if (k == 40) begin
            n_fail++;
            $display("[ERR] busy exp 0 got %b", busy);
            give_verdict();
        end
        chk("span", 8'h14, k[7:0]);
    endtask : conv
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk) chk("res rst", 8'h00, res);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) cfg <= rows[i][11:8];
            repeat (10) @(posedge clk);
            conv(i[0]);
            chk("res", rows[i][7:0], res);
            chk("wake", 8'h00, {7'h0, wake});
            chk("track", 8'h01, {7'h0, sample_en});
            chk("irq", {7'h0, rows[i][8]}, {7'h0, irq});
            chk("ref", {7'h0, rows[i][9]}, {7'h0, ref_internal});
            @(posedge clk) irq_clear <= 1'b1;
            @(posedge clk) irq_clear <= 1'b0;
        end
        @(posedge clk) cfg <= 4'h1;
        sleeping <= 1'b1;
        repeat (10) @(posedge clk);
        conv(1'b0);
        @(negedge clk) chk("wake", 8'h01, {7'h0, wake});
        conv(1'b0);
        chk("res last", 8'hA5, res);
        @(posedge clk) sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk) chk("busy", 8'h00, {7'h0, busy});
        chk("res clr", 8'h00, res);
        chk("irq rst", 8'h00, {7'h0, irq});
        chk("track rst", 8'h00, {7'h0, sample_en});
        @(negedge clk) chk("track", 8'h01, {7'h0, sample_en});
        give_verdict();
    end
endmodule : tb_sar_adc_control
